// [dial_seq.sv]
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module dial_seq
  import dial_pkg::*;
#(
  parameter logic [19:0] TICK_CYC_P   = TICK_CYC,
  parameter logic [15:0] NO_WINK_P    = NO_WINK_MS,
  parameter logic [15:0] NO_ANSWER_P  = NO_ANSWER_MS,
  parameter logic [15:0] DIGIT_GAP_P  = DIGIT_GAP_MS
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register port
  input  wire bus_req_t    bus_req,
  output logic [31:0]      rdata_q,
  output logic             irq_q,
  // terminal ready lead
  input  wire logic        dtr_pin,
  // line side
  input  wire logic        wink_pin,
  input  wire logic        answer_pin,
  output logic             offhook_q,
  output logic [3:0]       line_digit_q,
  output logic             line_stb_q,
  // control port messages
  output msg_t             msg_q
);

  // pin synchronisers: bit 0 dtr, bit 1 wink, bit 2 answer
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {answer_pin, wink_pin, dtr_pin};
      sync2_q <= sync1_q;
    end
  end
  logic dtr_s, wink_s, answer_s;
  assign dtr_s    = sync2_q[0];
  assign wink_s   = sync2_q[1];
  assign answer_s = sync2_q[2];

  // millisecond tick
  logic [19:0] tick_cnt_q, tick_cnt_d;
  logic        tick;
  always_comb begin
    tick       = (tick_cnt_q == TICK_CYC_P - 20'h00001);
    tick_cnt_d = tick ? 20'h00000 : tick_cnt_q + 20'h00001;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) tick_cnt_q <= 20'h00000;
    else     tick_cnt_q <= tick_cnt_d;
  end

  // bus decode
  logic cmd_wr, entry_wr, stat_rd;
  logic [7:0] cmd, chr;
  assign cmd_wr   = bus_req.wr && (bus_req.addr == OFS_CMD);
  assign entry_wr = bus_req.wr && (bus_req.addr == OFS_ENTRY);
  assign stat_rd  = bus_req.rd && (bus_req.addr == OFS_INT_STAT);
  assign cmd      = bus_req.wdata[7:0];
  assign chr      = bus_req.wdata[7:0];

  // call sequencer state
  call_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [3:0]  num_q [MAX_DIGITS];
  logic [3:0]  num_d [MAX_DIGITS];
  logic [3:0]  stor_q [MAX_DIGITS];
  logic [3:0]  stor_d [MAX_DIGITS];
  logic [3:0]  len_q, len_d, stor_len_q, stor_len_d, idx_q, idx_d;
  logic        stored_q, stored_d, store_mode_q, store_mode_d;
  logic        connected_q, connected_d, offhook_d, dtr_prev_q;
  logic        line_stb_d;
  logic [3:0]  line_digit_d;
  msg_t        msg_d;
  msg_kind_t   result_q, result_d;
  logic [INT_W-1:0] ev;
  logic        busy, launch, res_fire, is_digit;
  msg_kind_t   res_kind;

  assign busy = (state_q == S_WAIT_WINK) || (state_q == S_WINK) ||
                (state_q == S_SEND) || (state_q == S_WAIT_ANS);
  assign is_digit = (chr >= CHR_ZERO) && (chr <= CHR_NINE);

  // next state of the call sequencer
  always_comb begin
    state_d      = state_q;
    cnt_d        = tick ? cnt_q + 16'h0001 : cnt_q;
    num_d        = num_q;
    stor_d       = stor_q;
    len_d        = len_q;
    stor_len_d   = stor_len_q;
    idx_d        = idx_q;
    stored_d     = stored_q;
    store_mode_d = store_mode_q;
    connected_d  = connected_q;
    offhook_d    = offhook_q;
    line_stb_d   = 1'b0;
    line_digit_d = line_digit_q;
    msg_d        = '{valid: 1'b0, kind: M_NONE, digit: 4'h0};
    result_d     = result_q;
    ev           = '0;
    launch       = 1'b0;
    res_fire     = 1'b0;
    res_kind     = M_NONE;
    unique case (state_q)
      S_IDLE: begin
        // stored number dialed on a rising terminal ready lead
        if (dtr_s && !dtr_prev_q && stored_q && !connected_q) begin
          num_d         = stor_q;
          len_d         = stor_len_q;
          launch        = 1'b1;
          ev[INT_AUTO]  = 1'b1;
        end
      end
      S_COLLECT: begin
        if (entry_wr && is_digit && len_q < MAX_DIGITS) begin
          num_d[len_q] = chr[3:0] - CHR_ZERO[3:0];
          len_d        = len_q + 4'h1;
        end else if (entry_wr && chr == CHR_CR) begin
          state_d = S_IDLE;
          if (store_mode_q) begin
            stor_d     = num_q;
            stor_len_d = len_q;
            stored_d   = (len_q != 4'h0);
          end else if (len_q != 4'h0) begin
            launch = 1'b1;
          end
        end
      end
      S_WAIT_WINK: begin
        if (wink_s) begin
          state_d = S_WINK;
          cnt_d   = 16'h0000;
        end else if (tick && cnt_q == NO_WINK_P - 16'h0001) begin
          res_fire = 1'b1;
          res_kind = M_NO_WINK;
        end
      end
      S_WINK: begin
        if (!wink_s) begin
          if (cnt_q < SHORT_WINK_MS) begin
            res_fire = 1'b1;
            res_kind = M_SHORT_WINK;
          end else begin
            state_d = S_SEND;
            cnt_d   = 16'h0000;
            idx_d   = 4'h0;
          end
        end else if (tick && cnt_q >= LONG_WINK_MS) begin
          res_fire = 1'b1;
          res_kind = M_LONG_WINK;
        end
      end
      S_SEND: begin
        if (idx_q == len_q) begin
          msg_d   = '{valid: 1'b1, kind: M_WAIT, digit: 4'h0};
          state_d = S_WAIT_ANS;
          cnt_d   = 16'h0000;
        end else if (tick && cnt_q >= DIGIT_GAP_P - 16'h0001) begin
          line_stb_d    = 1'b1;
          line_digit_d  = num_q[idx_q];
          msg_d         = '{valid: 1'b1, kind: M_DIGIT,
                            digit: num_q[idx_q]};
          idx_d         = idx_q + 4'h1;
          cnt_d         = 16'h0000;
          ev[INT_DIGIT] = 1'b1;
        end
      end
      S_WAIT_ANS: begin
        if (answer_s) begin
          res_fire    = 1'b1;
          res_kind    = M_CONNECT;
          connected_d = 1'b1;
        end else if (tick && cnt_q == NO_ANSWER_P - 16'h0001) begin
          res_fire = 1'b1;
          res_kind = M_NO_CARRIER;
        end
      end
    endcase
    // commands are only taken when no attempt is running
    if (cmd_wr && !busy) begin
      if (cmd == CMD_DIAL || cmd == CMD_STORE) begin
        state_d      = S_COLLECT;
        store_mode_d = (cmd == CMD_STORE);
        len_d        = 4'h0;
      end else if (cmd == CMD_HANGUP) begin
        state_d     = S_IDLE;
        offhook_d   = 1'b0;
        connected_d = 1'b0;
      end
    end
    // start of a dial attempt, or its refusal
    if (launch) begin
      if (!dtr_s) begin
        res_fire = 1'b1;
        res_kind = M_DTR_OFF;
      end else if (connected_q) begin
        res_fire = 1'b1;
        res_kind = M_OFF_HOOK;
      end else begin
        state_d   = S_WAIT_WINK;
        cnt_d     = 16'h0000;
        offhook_d = 1'b1;
        msg_d     = '{valid: 1'b1, kind: M_DIALING, digit: 4'h0};
      end
    end
    // one result message ends each attempt
    if (res_fire) begin
      msg_d          = '{valid: 1'b1, kind: res_kind, digit: 4'h0};
      result_d       = res_kind;
      state_d        = S_IDLE;
      ev[INT_RESULT] = 1'b1;
      if (!connected_d) offhook_d = 1'b0;
    end
  end

  // call sequencer registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q      <= S_IDLE;
      cnt_q        <= 16'h0000;
      num_q        <= '{default: 4'h0};
      stor_q       <= '{default: 4'h0};
      len_q        <= 4'h0;
      stor_len_q   <= 4'h0;
      idx_q        <= 4'h0;
      stored_q     <= 1'b0;
      store_mode_q <= 1'b0;
      connected_q  <= 1'b0;
      offhook_q    <= 1'b0;
      dtr_prev_q   <= 1'b0;
      line_stb_q   <= 1'b0;
      line_digit_q <= 4'h0;
      msg_q        <= '{valid: 1'b0, kind: M_NONE, digit: 4'h0};
      result_q     <= M_NONE;
    end else begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      num_q        <= num_d;
      stor_q       <= stor_d;
      len_q        <= len_d;
      stor_len_q   <= stor_len_d;
      idx_q        <= idx_d;
      stored_q     <= stored_d;
      store_mode_q <= store_mode_d;
      connected_q  <= connected_d;
      offhook_q    <= offhook_d;
      dtr_prev_q   <= dtr_s;
      line_stb_q   <= line_stb_d;
      line_digit_q <= line_digit_d;
      msg_q        <= msg_d;
      result_q     <= result_d;
    end
  end

  // register file: sticky status, mask, read data, interrupt
  logic [INT_W-1:0] int_stat_q, int_stat_d, int_mask_q, int_mask_d;
  logic [31:0]      rdata_d;
  logic             irq_d;
  always_comb begin
    int_stat_d = (stat_rd ? '0 : int_stat_q) | ev; // set wins over clear
    int_mask_d = int_mask_q;
    if (bus_req.wr && bus_req.addr == OFS_INT_MASK)
      int_mask_d = bus_req.wdata[INT_W-1:0];
    irq_d   = |(int_stat_d & int_mask_d);
    rdata_d = 32'h00000000;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFS_STATUS: begin
          rdata_d[2:0]               = state_q;
          rdata_d[ST_OFFHOOK]        = offhook_q;
          rdata_d[ST_CONNECTED]      = connected_q;
          rdata_d[ST_STORED]         = stored_q;
          rdata_d[ST_BUSY]           = busy;
          rdata_d[ST_LEN_LSB +: 4]   = stor_len_q;
        end
        OFS_RESULT:   rdata_d[3:0]       = result_q;
        OFS_INT_STAT: rdata_d[INT_W-1:0] = int_stat_q;
        OFS_INT_MASK: rdata_d[INT_W-1:0] = int_mask_q;
        default:      rdata_d            = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      int_stat_q <= '0;
      int_mask_q <= INT_MASK_RST;
      rdata_q    <= 32'h00000000;
      irq_q      <= 1'b0;
    end else begin
      int_stat_q <= int_stat_d;
      int_mask_q <= int_mask_d;
      rdata_q    <= rdata_d;
      irq_q      <= irq_d;
    end
  end

  // checks
  a_len_bound: assert property (@(posedge core_clk) disable iff (rst)
    len_q <= MAX_DIGITS) else $error("digit count above limit");
  a_skip_char: assert property (@(posedge core_clk) disable iff (rst)
    state_q == S_COLLECT && entry_wr && !is_digit && chr != CHR_CR
      |=> len_q == $past(len_q)) else $error("non-digit was stored");
  a_dial_msg: assert property (@(posedge core_clk) disable iff (rst)
    $rose(offhook_q) |-> msg_q.valid && msg_q.kind == M_DIALING)
    else $error("seize without dialing notice");
  a_digit_echo: assert property (@(posedge core_clk) disable iff (rst)
    line_stb_q |-> msg_q.kind == M_DIGIT && msg_q.digit == line_digit_q)
    else $error("digit not echoed");
  a_no_wink: assert property (@(posedge core_clk) disable iff (rst)
    msg_q.kind == M_NO_WINK |-> $past(state_q) == S_WAIT_WINK &&
      $past(cnt_q) == NO_WINK_P - 16'h0001) else $error("bad no-wink");
  a_short_wink: assert property (@(posedge core_clk) disable iff (rst)
    msg_q.kind == M_SHORT_WINK |-> $past(cnt_q) < SHORT_WINK_MS)
    else $error("short wink misjudged");
  a_long_wink: assert property (@(posedge core_clk) disable iff (rst)
    msg_q.kind == M_LONG_WINK |-> $past(cnt_q) >= LONG_WINK_MS &&
      $past(wink_s)) else $error("long wink misjudged");
  a_no_carrier: assert property (@(posedge core_clk) disable iff (rst)
    msg_q.kind == M_NO_CARRIER |-> $past(state_q) == S_WAIT_ANS && !offhook_q)
    else $error("bad no-carrier");
  a_connect: assert property (@(posedge core_clk) disable iff (rst)
    state_q == S_WAIT_ANS && answer_s |=> msg_q.kind == M_CONNECT &&
      connected_q && offhook_q) else $error("answer not reported");
  a_dtr_refuse: assert property (@(posedge core_clk) disable iff (rst)
    msg_q.kind == M_DTR_OFF |-> !$past(dtr_s) && state_q == S_IDLE)
    else $error("dialed with terminal ready off");
  a_busy_line: assert property (@(posedge core_clk) disable iff (rst)
    msg_q.kind == M_OFF_HOOK |-> offhook_q && connected_q)
    else $error("off-hook refusal dropped the line");
  a_hook_held: assert property (@(posedge core_clk) disable iff (rst)
    $fell(offhook_q) && $past(busy) |-> msg_q.valid)
    else $error("attempt ended without result");
  a_hangup: assert property (@(posedge core_clk) disable iff (rst)
    cmd_wr && cmd == CMD_HANGUP && !busy |=> !offhook_q && !connected_q)
    else $error("hang-up ignored");
  a_erase: assert property (@(posedge core_clk) disable iff (rst)
    state_q == S_COLLECT && store_mode_q && entry_wr && chr == CHR_CR &&
      len_q == 4'h0 |=> !stored_q) else $error("empty store kept number");

endmodule
`default_nettype wire

// [dial_pkg.sv]
// Functional notes
// - up to 12 digits, return ends entry
// - dialing notice, echo digits, then wait notice
// - no wink within 5 s fails call
// - wink under 120 ms is short
// - wink over 320 ms is long
// - no answer within 30 s fails call
// - answer gives connect result
// - refuse dialing while terminal ready is off
// - dial while off-hook reports off-hook
// - commands ignored while a dial attempt runs
// - hang-up returns line on-hook
// - stored number dialed when terminal ready rises
// - empty store erases number, stops auto dial
`default_nettype none
package dial_pkg;
  // clock and millisecond tick
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_NS       = 1000000;
  localparam logic [19:0] TICK_CYC      = 20'(TICK_NS / CLK_PERIOD_NS);
  // call progress times in milliseconds, and the digit limit
  localparam logic [15:0] NO_WINK_MS    = 16'h1388;
  localparam logic [15:0] SHORT_WINK_MS = 16'h0078;
  localparam logic [15:0] LONG_WINK_MS  = 16'h0140;
  localparam logic [15:0] NO_ANSWER_MS  = 16'h7530;
  localparam logic [15:0] DIGIT_GAP_MS  = 16'h0064;
  localparam logic [3:0]  MAX_DIGITS    = 4'hC;
  // register offsets
  localparam logic [7:0]  OFS_CMD       = 8'h00;
  localparam logic [7:0]  OFS_ENTRY     = 8'h04;
  localparam logic [7:0]  OFS_STATUS    = 8'h08;
  localparam logic [7:0]  OFS_RESULT    = 8'h0C;
  localparam logic [7:0]  OFS_INT_STAT  = 8'h10;
  localparam logic [7:0]  OFS_INT_MASK  = 8'h14;
  // command codes and entry characters
  localparam logic [7:0]  CMD_DIAL      = 8'h01;
  localparam logic [7:0]  CMD_STORE     = 8'h02;
  localparam logic [7:0]  CMD_HANGUP    = 8'h03;
  localparam logic [7:0]  CHR_CR        = 8'h0D;
  localparam logic [7:0]  CHR_ZERO      = 8'h30;
  localparam logic [7:0]  CHR_NINE      = 8'h39;
  // interrupt bits
  localparam int unsigned INT_W         = 3;
  localparam int unsigned INT_RESULT    = 0;
  localparam int unsigned INT_DIGIT     = 1;
  localparam int unsigned INT_AUTO      = 2;
  localparam logic [2:0]  INT_MASK_RST  = 3'h0;
  // status register fields
  localparam int unsigned ST_OFFHOOK    = 3;
  localparam int unsigned ST_CONNECTED  = 4;
  localparam int unsigned ST_STORED     = 5;
  localparam int unsigned ST_BUSY       = 6;
  localparam int unsigned ST_LEN_LSB    = 8;

  typedef enum logic [2:0] {
    S_IDLE, S_COLLECT, S_WAIT_WINK, S_WINK, S_SEND, S_WAIT_ANS
  } call_state_t;

  typedef enum logic [3:0] {
    M_NONE, M_DIALING, M_DIGIT, M_WAIT, M_CONNECT, M_NO_WINK,
    M_SHORT_WINK, M_LONG_WINK, M_NO_CARRIER, M_DTR_OFF, M_OFF_HOOK
  } msg_kind_t;

  typedef struct packed {
    logic      valid;
    msg_kind_t kind;
    logic [3:0] digit;
  } msg_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bus_req_t;
endpackage
`default_nettype wire

// [office_model.sv]
`timescale 1ns/1ps
`default_nettype none
module office_model #(
  parameter int TICK = 10
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // line from the unit
  input  wire logic        offhook_q,
  input  wire logic        line_stb_q,
  // scenario settings
  input  wire logic [15:0] wink_ms,
  input  wire logic        ans_en,
  // office signalling
  output logic             wink_pin,
  output logic             answer_pin
);
  int q;

  // wink after seizure, answer once the digits have gone quiet
  initial begin
    wink_pin = 1'b0;
    answer_pin = 1'b0;
    forever begin
      while (!(offhook_q === 1'b1 && rst === 1'b0)) @(posedge core_clk);
      repeat (2 * TICK) @(posedge core_clk);
      if (wink_ms != 16'h0000) begin
        wink_pin <= 1'b1;
        repeat (wink_ms * TICK) @(posedge core_clk);
        wink_pin <= 1'b0;
      end
      q = 0;
      // quiet longer than the digit gap means dialing is over
      while (offhook_q === 1'b1 && q < 4 * TICK) begin
        @(posedge core_clk);
        q = (line_stb_q === 1'b1) ? 0 : q + 1;
      end
      if (offhook_q === 1'b1 && ans_en) answer_pin <= 1'b1;
      while (offhook_q === 1'b1) @(posedge core_clk);
      answer_pin <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [switched_dial_call_progress_test.sv]
`timescale 1ns/1ps
`default_nettype none
module switched_dial_call_progress_test;
  import dial_pkg::*;
  localparam int TK = 10;
  logic        core_clk, rst, dtr_pin, ans_en;
  logic        wink_pin, answer_pin, offhook_q, line_stb_q, irq_q;
  logic [3:0]  line_digit_q;
  logic [15:0] wink_ms;
  logic [31:0] rdata_q, rv;
  bus_req_t    bus_req;
  msg_t        msg_q;
  int          bad_count, compares, seed, cyc, nres;
  msg_kind_t   last_res;
  msg_t        mq[$];
  logic [3:0]  lq[$], num[$];

  dial_seq #(.TICK_CYC_P(20'h0000A), .NO_WINK_P(16'h0032),
    .NO_ANSWER_P(16'h0064), .DIGIT_GAP_P(16'h0002)) dut (
    .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .rdata_q(rdata_q),
    .irq_q(irq_q), .dtr_pin(dtr_pin), .wink_pin(wink_pin),
    .answer_pin(answer_pin), .offhook_q(offhook_q),
    .line_digit_q(line_digit_q), .line_stb_q(line_stb_q), .msg_q(msg_q));

  office_model #(.TICK(TK)) office (
    .core_clk(core_clk), .rst(rst), .offhook_q(offhook_q),
    .line_stb_q(line_stb_q), .wink_ms(wink_ms), .ans_en(ans_en),
    .wink_pin(wink_pin), .answer_pin(answer_pin));

  // clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // collect messages and line digits, cut a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (msg_q.valid === 1'b1) begin
      mq.push_back(msg_q);
      if (msg_q.kind >= M_CONNECT) begin
        last_res = msg_q.kind;
        nres++;
      end
    end
    if (line_stb_q === 1'b1) lq.push_back(line_digit_q);
    if (cyc == 60000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    bus_req <= '0;
  endtask

  // read data stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge core_clk);
    bus_req <= '0;
    #1 rv = rdata_q;
  endtask

  // random number of n digits, n of 0 picks a random length
  task automatic rand_num(input int n);
    num = {};
    if (n == 0) n = 1 + ($unsigned($random(seed)) % 12);
    repeat (n) num.push_back(4'($unsigned($random(seed)) % 10));
  endtask

  // command, digits with stray characters, a thirteenth digit after twelve, return
  task automatic enter(input logic [7:0] cmd);
    wr(OFS_CMD, 32'(cmd));
    foreach (num[i]) begin
      if ($random(seed) % 3 == 0) wr(OFS_ENTRY, 32'h0000_0041);
      wr(OFS_ENTRY, 32'(CHR_ZERO + 8'(num[i])));
    end
    if (num.size() == 12) wr(OFS_ENTRY, 32'h0000_0037);
    wr(OFS_ENTRY, 32'(CHR_CR));
  endtask

  function automatic msg_kind_t expect_res(int w, logic a, logic d,
                                           logic oh);
    if (!d) return M_DTR_OFF;
    if (oh) return M_OFF_HOOK;
    if (w == 0) return M_NO_WINK;
    if (w < int'(SHORT_WINK_MS)) return M_SHORT_WINK;
    if (w > int'(LONG_WINK_MS)) return M_LONG_WINK;
    return a ? M_CONNECT : M_NO_CARRIER;
  endfunction

  // one dial attempt, typed or started by the ready lead
  task automatic attempt(input int w, input logic a, input logic oh,
                         input logic au);
    int        n0;
    msg_kind_t e;
    e = expect_res(w, a, au | dtr_pin, oh);
    wink_ms = 16'(w);
    ans_en = a;
    mq = {};
    lq = {};
    n0 = nres;
    if (au) dtr_pin <= 1'b1;
    else enter(CMD_DIAL);
    if (e != M_DTR_OFF && e != M_OFF_HOOK) wr(OFS_CMD, 32'(CMD_HANGUP));
    for (int i = 0; i < 20000 && nres == n0; i++) @(posedge core_clk);
    #1;
    chk(32'(nres - n0), 32'h1);
    chk(32'(last_res), 32'(e));
    chk(32'(offhook_q), 32'(e == M_CONNECT || oh));
    if (e != M_DTR_OFF && e != M_OFF_HOOK) begin
      chk(32'(mq[0].kind), 32'(M_DIALING));
    end
    if (e == M_CONNECT || e == M_NO_CARRIER) begin
      chk(32'(lq.size()), 32'(num.size()));
      foreach (num[i]) begin
        chk(32'(lq[i]), 32'(num[i]));
        chk(32'({mq[i + 1].kind, mq[i + 1].digit}),
            32'({M_DIGIT, num[i]}));
      end
      chk(32'(mq[num.size() + 1].kind), 32'(M_WAIT));
    end
    while (wink_pin === 1'b1) @(posedge core_clk);
  endtask

  // main sequence
  initial begin
    int wl[4] = '{0, 50, 400, 200};
    seed = 76;
    bad_count = 0;
    compares = 0;
    cyc = 0;
    nres = 0;
    rst = 1'b1;
    dtr_pin = 1'b0;
    ans_en = 1'b0;
    wink_ms = 16'h0000;
    bus_req = '0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(OFS_INT_MASK);
    chk(rv, 32'(INT_MASK_RST));
    rd(8'h20);
    chk(rv, 32'h0);
    rand_num(0);
    attempt(200, 1'b1, 1'b0, 1'b0);
    dtr_pin <= 1'b1;
    // refused attempt left its result bit; clear it before unmasking
    rd(OFS_INT_STAT);
    chk(rv, 32'h1);
    wr(OFS_INT_MASK, 32'h1);
    #1;
    chk(32'(irq_q), 32'h0);
    for (int k = 0; k < 4; k++) begin
      rand_num(k == 3 ? 12 : 0);
      attempt(wl[k], 1'b0, 1'b0, 1'b0);
    end
    chk(32'(irq_q), 32'h1);
    rd(OFS_INT_STAT);
    chk(rv & 32'h1, 32'h1);
    rd(OFS_RESULT);
    chk(rv, 32'(M_NO_CARRIER));
    chk(32'(irq_q), 32'h0);
    rand_num(0);
    attempt(200, 1'b1, 1'b0, 1'b0);
    attempt(200, 1'b1, 1'b1, 1'b0);
    wr(OFS_CMD, 32'(CMD_HANGUP));
    repeat (2) @(posedge core_clk);
    chk(32'(offhook_q), 32'h0);
    rand_num(0);
    enter(CMD_STORE);
    rd(OFS_STATUS);
    chk(rv & 32'h0F20, 32'(num.size() << 8) | 32'h20);
    dtr_pin <= 1'b0;
    repeat (5) @(posedge core_clk);
    attempt(200, 1'b1, 1'b0, 1'b1);
    wr(OFS_CMD, 32'(CMD_HANGUP));
    num = {};
    enter(CMD_STORE);
    rd(OFS_STATUS);
    chk(rv & 32'h20, 32'h0);
    dtr_pin <= 1'b0;
    repeat (5) @(posedge core_clk);
    mq = {};
    dtr_pin <= 1'b1;
    repeat (30) @(posedge core_clk);
    chk(32'(mq.size()), 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
